// *** hw/trim_pkg.sv ***
// Purpose: Shared constants, types and gain table for the gain/offset trim.
// Assumes: Trim registers are 16 bits wide and sit in the low half of a bus word.
// Notes: Register indices are word indices; byte address is four times one.
package trim_pkg;

  // Datapath widths
  localparam int unsigned SAMPLE_W = 14;
  localparam int unsigned OFFSET_W = 10;
  localparam int unsigned GAIN_W = 5;
  localparam int unsigned FACTOR_W = 16;
  localparam int unsigned DIFF_W = 15;
  localparam int unsigned FRAC_BITS = 14;
  localparam int unsigned REG_W = 16;

  // Gain step as a figure in millidecibels (0.2 dB per code)
  localparam int unsigned GAIN_STEP_MDB = 200;

  // Register word indices
  localparam logic [5:0] IDX_CTRL = 6'h03;
  localparam logic [5:0] IDX_C11_ODD = 6'h29;
  localparam logic [5:0] IDX_C11_EVEN = 6'h2A;
  localparam logic [5:0] IDX_C12_ODD = 6'h2B;
  localparam logic [5:0] IDX_STATUS = 6'h30;
  localparam logic [5:0] IDX_COUNT = 6'h31;

  // Field positions inside a trim register
  localparam int unsigned GAIN_MSB = 15;
  localparam int unsigned GAIN_LSB = 11;
  localparam int unsigned RSVD_BIT = 10;
  localparam int unsigned OFFSET_MSB = 9;
  localparam int unsigned OFFSET_LSB = 0;

  // Field positions inside the control register
  localparam int unsigned GAIN_APPLY_BIT = 12;
  localparam int unsigned OFFSET_APPLY_BIT = 8;

  // Values after reset
  localparam logic [15:0] TRIM_RESET = 16'h0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Arithmetic constants, gain factor is unsigned Q2.14
  localparam logic [15:0] UNITY_FACTOR = 16'h4000;
  localparam logic signed [31:0] ROUND_HALF = 32'sh0000_2000;
  localparam logic signed [31:0] SAT_MAX = 32'sh0000_1FFF;
  localparam logic signed [31:0] SAT_MIN = 32'shFFFF_E000;
  localparam logic [13:0] SAT_MAX_CODE = 14'h1FFF;
  localparam logic [13:0] SAT_MIN_CODE = 14'h2000;

  typedef logic [SAMPLE_W-1:0] sample_t;
  typedef logic [REG_W-1:0] trim_word_t;

  // Linear factor 10^(code*0.2/20) in Q2.14, rounded to nearest
  function automatic logic [15:0] gain_factor(input logic [4:0] code);
    logic [15:0] f;
    f = UNITY_FACTOR;
    case (code)
      5'h00: f = 16'h4000;
      5'h01: f = 16'h417E;
      5'h02: f = 16'h4304;
      5'h03: f = 16'h4494;
      5'h04: f = 16'h462D;
      5'h05: f = 16'h47CF;
      5'h06: f = 16'h497B;
      5'h07: f = 16'h4B32;
      5'h08: f = 16'h4CF2;
      5'h09: f = 16'h4EBD;
      5'h0A: f = 16'h5092;
      5'h0B: f = 16'h5273;
      5'h0C: f = 16'h545E;
      5'h0D: f = 16'h5655;
      5'h0E: f = 16'h5858;
      5'h0F: f = 16'h5A67;
      5'h10: f = 16'h5C82;
      5'h11: f = 16'h5EAA;
      5'h12: f = 16'h60DE;
      5'h13: f = 16'h6320;
      5'h14: f = 16'h656F;
      5'h15: f = 16'h67CC;
      5'h16: f = 16'h6A37;
      5'h17: f = 16'h6CB0;
      5'h18: f = 16'h6F38;
      5'h19: f = 16'h71CF;
      5'h1A: f = 16'h7476;
      5'h1B: f = 16'h772C;
      5'h1C: f = 16'h79F3;
      5'h1D: f = 16'h7CCA;
      5'h1E: f = 16'h7FB2;
      5'h1F: f = 16'h82AC;
      default: f = UNITY_FACTOR;
    endcase
    return f;
  endfunction

endpackage

// *** hw/trim_cfg_if.sv ***
// Purpose: Carries one converter's trim settings from registers to its lane.
// Assumes: Settings are static while samples flow, or changes may split.
// Notes: The register side drives, the lane side only reads.
`timescale 1ns/10ps
`default_nettype none
interface trim_cfg_if;
  logic [4:0] odd_gain;
  logic [4:0] even_gain;
  logic [9:0] odd_offset;
  logic [9:0] even_offset;
  logic gain_apply;
  logic offset_apply;

  modport regs (
    output odd_gain, even_gain, odd_offset, even_offset,
    output gain_apply, offset_apply
  );
  modport lane (
    input odd_gain, even_gain, odd_offset, even_offset,
    input gain_apply, offset_apply
  );
endinterface
`default_nettype wire

// *** hw/sample_trim_lane.sv ***
// Purpose: Offset subtraction then digital gain for one converter stream.
// Assumes: Samples are 14-bit two's complement, lower resolutions MSB-aligned.
// Notes: Two cycles from input to output; result saturates to 14 bits.
`timescale 1ns/10ps
`default_nettype none
module sample_trim_lane import trim_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  trim_cfg_if.lane cfg,
  input wire logic valid_i,
  input wire logic odd_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  output logic valid_o,
  output logic odd_o,
  output logic [SAMPLE_W-1:0] sample_o
);

  logic s1_valid_q, s1_valid_d;
  logic s1_odd_q, s1_odd_d;
  logic signed [DIFF_W-1:0] s1_diff_q, s1_diff_d;
  logic [FACTOR_W-1:0] s1_factor_q, s1_factor_d;
  logic valid_q, valid_d;
  logic odd_q, odd_d;
  logic [SAMPLE_W-1:0] sample_q, sample_d;

  // Stage 1: pick this phase's settings, subtract offset, look up gain
  always_comb begin
    logic [4:0] gain_sel;
    logic [9:0] off_sel;
    logic [DIFF_W-1:0] off_ext;
    gain_sel = odd_i ? cfg.odd_gain : cfg.even_gain;
    off_sel = odd_i ? cfg.odd_offset : cfg.even_offset;
    // Offset LSB weighs one 14-bit LSB whatever the resolution
    off_ext = {{(DIFF_W-OFFSET_W){off_sel[OFFSET_W-1]}}, off_sel};
    if (!cfg.offset_apply) begin
      off_ext = '0;
    end
    s1_diff_d = signed'({sample_i[SAMPLE_W-1], sample_i} - off_ext);
    // Unity factor when gain is off, so one multiplier serves both cases
    s1_factor_d = cfg.gain_apply ? gain_factor(gain_sel) : UNITY_FACTOR;
    s1_valid_d = valid_i;
    s1_odd_d = odd_i;
  end

  // Stage 2: multiply, round to nearest, saturate
  always_comb begin
    logic signed [31:0] diff_w;
    logic signed [31:0] fac_w;
    logic signed [31:0] prod;
    logic signed [31:0] scaled;
    diff_w = 32'(s1_diff_q);
    fac_w = signed'({16'h0000, s1_factor_q});
    prod = diff_w * fac_w;
    scaled = (prod + ROUND_HALF) >>> FRAC_BITS;
    // Gain up to about 2x can overflow a full-scale code, clip it
    if (scaled > SAT_MAX) begin
      sample_d = SAT_MAX_CODE;
    end else if (scaled < SAT_MIN) begin
      sample_d = SAT_MIN_CODE;
    end else begin
      sample_d = scaled[SAMPLE_W-1:0];
    end
    valid_d = s1_valid_q;
    odd_d = s1_odd_q;
  end

  // Pipeline registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_valid_q <= 1'b0;
      s1_odd_q <= 1'b0;
      s1_diff_q <= '0;
      s1_factor_q <= UNITY_FACTOR;
      valid_q <= 1'b0;
      odd_q <= 1'b0;
      sample_q <= '0;
    end else begin
      s1_valid_q <= s1_valid_d;
      s1_odd_q <= s1_odd_d;
      s1_diff_q <= s1_diff_d;
      s1_factor_q <= s1_factor_d;
      valid_q <= valid_d;
      odd_q <= odd_d;
      sample_q <= sample_d;
    end
  end

  assign valid_o = valid_q;
  assign odd_o = odd_q;
  assign sample_o = sample_q;

endmodule
`default_nettype wire

// *** hw/channel_gain_offset_trim.sv ***
// Purpose: Gain and offset trim registers for converters 11 and 12.
// Assumes: Classic Wishbone slave, 32-bit data, word-aligned registers.
// Notes: Converter 12 carries odd samples only; its phase input is fixed.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module channel_gain_offset_trim import trim_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic conv11_valid_i,
  input wire logic conv11_odd_i,
  input wire logic [13:0] conv11_sample_i,
  input wire logic conv12_valid_i,
  input wire logic [13:0] conv12_sample_i,
  output logic conv11_valid_o,
  output logic conv11_odd_o,
  output logic [13:0] conv11_sample_o,
  output logic conv12_valid_o,
  output logic [13:0] conv12_sample_o
);

  // Register map, byte address is four times the word index:
  //   0x0C control, bit 12 gain apply and bit 8 offset apply
  //   0xA4 converter 11 odd trim word
  //   0xA8 converter 11 even trim word
  //   0xAC converter 12 odd trim word
  //   0xC0 status, last corrected sample of each lane, read only
  //   0xC4 count of converter 11 outputs, any write clears it
  // A trim word holds the gain code in 15..11 and the offset in 9..0;
  // bit 10 is reserved and bits 31..16 of the bus word read as zero.
  // Unmapped words still answer, so a stray access cannot hang a master.

  // Bus timing for one request:
  //   edge 0: strobe seen with ack low, read word is registered
  //   cycle 1: ack high, read data stands on the bus
  //   edge 1: a write lands, ack falls
  // The ack-low qualifier keeps a strobe held past ack from writing on every edge;
  // such a master gets a second answer, and a second write, two cycles later.

  // Merge a bus write into a 16-bit trim word by byte lane
  // Lane 0 carries offset bits 7..0, lane 1 the gain code and offset 9..8;
  // the other lanes have no storage behind them and are ignored.
  function automatic trim_word_t merge_trim(input trim_word_t old,
                                            input logic [31:0] wdat,
                                            input logic [3:0] sel);
    trim_word_t w;
    w = old;
    if (sel[0]) begin
      w[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      w[15:8] = wdat[15:8];
    end
    // Reserved bit is never stored, so it always reads back as zero
    w[RSVD_BIT] = 1'b0;
    return w;
  endfunction

  // Word index decode of the byte address
  function automatic logic [5:0] word_index(input logic [7:0] adr);
    return adr[7:2];
  endfunction

  // Place a 16-bit trim word in the low half of a bus word
  function automatic logic [31:0] trim_read(input trim_word_t w);
    return {16'h0000, w};
  endfunction

  // Bus slave state
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  // Register file state; only the two enables of the control word exist
  // here, so every other control bit reads back as zero
  trim_word_t c11_odd_q, c11_odd_d;
  trim_word_t c11_even_q, c11_even_d;
  trim_word_t c12_odd_q, c12_odd_d;
  logic gain_apply_q, gain_apply_d;
  logic offset_apply_q, offset_apply_d;
  logic [31:0] count_q, count_d;

  // Request decode; the low two address bits are ignored, so any byte
  // address inside a word reaches that word
  logic req;
  logic wr_fire;
  logic [5:0] idx;
  logic count_clr;

  // Lane results, read back through the status word
  // and the counter; they also drive the sample outputs directly
  logic c11_valid;
  logic c11_odd;
  logic [13:0] c11_sample;
  logic c12_valid;
  logic [13:0] c12_sample;

  trim_cfg_if c11_cfg ();
  trim_cfg_if c12_cfg ();

  assign req = wb_cyc_i & wb_stb_i;
  assign idx = word_index(wb_adr_i);
  // Write commits on the edge where the master sees ack high
  assign wr_fire = req & wb_we_i & ack_q;

  // Bus handshake and read data; ack lasts one cycle, then drops
  // Read data is registered at the taking edge, so it stands for the whole
  // ack cycle and stays until the next read or write; a late sample update cannot
  // tear a status word the master is already looking at.
  always_comb begin
    ack_d = req & ~ack_q;
    rdat_d = rdat_q;
    if (req & ~ack_q) begin
      case (idx)
        IDX_CTRL: begin
          rdat_d = WORD_ZERO;
          rdat_d[GAIN_APPLY_BIT] = gain_apply_q;
          rdat_d[OFFSET_APPLY_BIT] = offset_apply_q;
        end
        IDX_C11_ODD: begin
          rdat_d = trim_read(c11_odd_q);
        end
        IDX_C11_EVEN: begin
          rdat_d = trim_read(c11_even_q);
        end
        IDX_C12_ODD: begin
          rdat_d = trim_read(c12_odd_q);
        end
        IDX_STATUS: begin
          rdat_d = {2'b00, c12_sample, 2'b00, c11_sample};
        end
        IDX_COUNT: begin
          rdat_d = count_q;
        end
        default: begin
          // Unmapped addresses still answer, with zero
          rdat_d = WORD_ZERO;
        end
      endcase
    end
  end

  // Reset drops ack mid-transfer; the master must restart after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= WORD_ZERO;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Register writes; unmapped and read-only words ignore writes
  // Control takes only byte lane 1, where both enables live; a write with
  // only lane 0 set leaves the enables alone.
  always_comb begin
    c11_odd_d = c11_odd_q;
    c11_even_d = c11_even_q;
    c12_odd_d = c12_odd_q;
    gain_apply_d = gain_apply_q;
    offset_apply_d = offset_apply_q;
    if (wr_fire) begin
      case (idx)
        IDX_CTRL: begin
          if (wb_sel_i[1]) begin
            gain_apply_d = wb_dat_i[GAIN_APPLY_BIT];
            offset_apply_d = wb_dat_i[OFFSET_APPLY_BIT];
          end
        end
        IDX_C11_ODD: begin
          c11_odd_d = merge_trim(c11_odd_q, wb_dat_i, wb_sel_i);
        end
        IDX_C11_EVEN: begin
          c11_even_d = merge_trim(c11_even_q, wb_dat_i, wb_sel_i);
        end
        IDX_C12_ODD: begin
          c12_odd_d = merge_trim(c12_odd_q, wb_dat_i, wb_sel_i);
        end
        default: begin
          c11_odd_d = c11_odd_q;
        end
      endcase
    end
  end

  // Reset leaves every lane in plain pass-through: no gain, no offset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c11_odd_q <= TRIM_RESET;
      c11_even_q <= TRIM_RESET;
      c12_odd_q <= TRIM_RESET;
      gain_apply_q <= 1'b0;
      offset_apply_q <= 1'b0;
    end else begin
      c11_odd_q <= c11_odd_d;
      c11_even_q <= c11_even_d;
      c12_odd_q <= c12_odd_d;
      gain_apply_q <= gain_apply_d;
      offset_apply_q <= offset_apply_d;
    end
  end

  // Corrected-sample counter; a new sample beats a same-cycle clear, so
  // no output is lost when software clears while the stream runs.
  // Any write clears it, so software never has to compute a value.
  // The counter wraps after 2^32 outputs; software reads differences.
  assign count_clr = wr_fire & (idx == IDX_COUNT);

  always_comb begin
    count_d = count_q;
    if (count_clr) begin
      count_d = COUNT_RESET;
    end
    if (c11_valid) begin
      count_d = (count_clr ? COUNT_RESET : count_q) + 32'h0000_0001;
    end
  end

  // Counter register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // Converter 11 settings, one word per sample phase
  // Both enables are global: one write to the control word switches
  // gain or offset on for every lane at once.
  assign c11_cfg.odd_gain = c11_odd_q[GAIN_MSB:GAIN_LSB];
  assign c11_cfg.odd_offset = c11_odd_q[OFFSET_MSB:OFFSET_LSB];
  assign c11_cfg.even_gain = c11_even_q[GAIN_MSB:GAIN_LSB];
  assign c11_cfg.even_offset = c11_even_q[OFFSET_MSB:OFFSET_LSB];
  assign c11_cfg.gain_apply = gain_apply_q;
  assign c11_cfg.offset_apply = offset_apply_q;

  // Converter 12 only has odd trim here; even side stays neutral
  // Neutral even settings mean a stray even phase would pass through
  // unchanged rather than borrow the odd trim.
  assign c12_cfg.odd_gain = c12_odd_q[GAIN_MSB:GAIN_LSB];
  assign c12_cfg.odd_offset = c12_odd_q[OFFSET_MSB:OFFSET_LSB];
  assign c12_cfg.even_gain = 5'h00;
  assign c12_cfg.even_offset = 10'h000;
  assign c12_cfg.gain_apply = gain_apply_q;
  assign c12_cfg.offset_apply = offset_apply_q;

  // Converter 11 lane, both phases
  // Each lane samples its settings in the input cycle, so a write landing
  // between an odd and an even sample splits them across settings.
  // Software should change trim only while the stream is idle.
  sample_trim_lane u_lane11 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg(c11_cfg.lane),
    .valid_i(conv11_valid_i),
    .odd_i(conv11_odd_i),
    .sample_i(conv11_sample_i),
    .valid_o(c11_valid),
    .odd_o(c11_odd),
    .sample_o(c11_sample)
  );

  // Converter 12 lane, phase tied to odd
  // Its phase input is fixed, so only the odd trim word can act on this
  // stream; the lane's phase output is therefore left open.
  sample_trim_lane u_lane12 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg(c12_cfg.lane),
    .valid_i(conv12_valid_i),
    .odd_i(1'b1),
    .sample_i(conv12_sample_i),
    .valid_o(c12_valid),
    .odd_o(),
    .sample_o(c12_sample)
  );

  // Outputs come from the bus and lane flip-flops
  // No logic sits between those flip-flops and the pins, so output timing
  // is set by the clock-to-out of a register alone.
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign conv11_valid_o = c11_valid;
  assign conv11_odd_o = c11_odd;
  assign conv11_sample_o = c11_sample;
  assign conv12_valid_o = c12_valid;
  assign conv12_sample_o = c12_sample;

endmodule
`default_nettype wire

// *** verification/trim_monitor.sv ***
// Purpose: Bus and sample-lane checks for the gain/offset trim block.
// Assumes: Sees only top ports; global enables shadowed from bus writes.
// Notes: Bypass checks hold only while both global enables are clear.
`timescale 1ns/10ps
`default_nettype none
module trim_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic conv11_valid_i,
  input wire logic conv11_odd_i,
  input wire logic [13:0] conv11_sample_i,
  input wire logic conv12_valid_i,
  input wire logic [13:0] conv12_sample_i,
  input wire logic conv11_valid_o,
  input wire logic conv11_odd_o,
  input wire logic [13:0] conv11_sample_o,
  input wire logic conv12_valid_o,
  input wire logic [13:0] conv12_sample_o
);
  logic [1:0] en_q;
  logic [1:0] en_d;
  logic [5:0] idx;
  assign idx = wb_adr_i[7:2];
  // Shadow enables; the write lands on the edge that sees ack high
  always_comb begin
    en_d = en_q;
    if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && idx == 6'h03
        && wb_sel_i[1]) begin
      en_d = {wb_dat_i[12], wb_dat_i[8]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 2'h0;
    end else begin
      en_q <= en_d;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request and single-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_next;
    s_req |=> s_ack_once;
  endproperty
  property p_no_spurious;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  property p_trim_read;
    wb_ack_o && !wb_we_i && idx inside {6'h29, 6'h2A, 6'h2B}
      |-> wb_dat_o[31:16] == 16'h0000 && !wb_dat_o[10];
  endproperty
  property p_lat11;
    conv11_valid_i
      |-> ##2 conv11_valid_o && conv11_odd_o == $past(conv11_odd_i, 2);
  endproperty
  property p_idle11;
    !conv11_valid_i |-> ##2 !conv11_valid_o;
  endproperty
  property p_lat12;
    conv12_valid_i |-> ##2 conv12_valid_o;
  endproperty
  property p_bypass11;
    conv11_valid_i && en_q == 2'h0
      |-> ##2 conv11_sample_o == $past(conv11_sample_i, 2);
  endproperty
  property p_bypass12;
    conv12_valid_i && en_q == 2'h0
      |-> ##2 conv12_sample_o == $past(conv12_sample_i, 2);
  endproperty
  // Reset itself is the cause here, so it cannot disable the check
  property p_reset_quiet;
    disable iff (1'b0) rst_i [*3] |-> !wb_ack_o && !conv11_valid_o
      && !conv12_valid_o && conv11_sample_o == 14'h0000;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  a_no_spurious: assert property (p_no_spurious) else $error("stray ack");
  a_trim_read: assert property (p_trim_read) else $error("bit10 set");
  a_lat11: assert property (p_lat11) else $error("conv11 phase");
  a_idle11: assert property (p_idle11) else $error("stray conv11 valid");
  a_lat12: assert property (p_lat12) else $error("conv12 latency");
  a_bypass11: assert property (p_bypass11) else $error("bypass11");
  a_bypass12: assert property (p_bypass12) else $error("bypass12");
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset");
endmodule
bind channel_gain_offset_trim trim_monitor trim_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .conv11_valid_i(conv11_valid_i), .conv11_odd_i(conv11_odd_i),
  .conv11_sample_i(conv11_sample_i), .conv12_valid_i(conv12_valid_i),
  .conv12_sample_i(conv12_sample_i), .conv11_valid_o(conv11_valid_o),
  .conv11_odd_o(conv11_odd_o), .conv11_sample_o(conv11_sample_o),
  .conv12_valid_o(conv12_valid_o), .conv12_sample_o(conv12_sample_o)
);
`default_nettype wire

// *** verification/channel_gain_offset_trim_tb_top.sv ***
// Purpose: Register and sample-path tests for the gain/offset trim block.
// Assumes: Wishbone answers after one cycle; lanes have two cycles latency.
// Notes: Expected samples come from a real-valued gain model, not the table.
`timescale 1ns/10ps
`default_nettype none
module channel_gain_offset_trim_tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic conv11_valid_i, conv11_odd_i, conv12_valid_i;
  logic conv11_valid_o, conv11_odd_o, conv12_valid_o;
  logic [13:0] conv11_sample_i, conv12_sample_i;
  logic [13:0] conv11_sample_o, conv12_sample_o;
  logic gen, oen;
  logic [4:0] g11o, g11e, g12;
  logic [9:0] o11o, o11e, o12;
  logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h0F, 5'h1F};
  int error_cnt = 0;
  int comparisons = 0;

  channel_gain_offset_trim channel_gain_offset_trim_inst (.*);

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_smp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t sample %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; request held until ack is seen at an edge
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    // Answer one cycle after the taking edge; the watchdog ends a hang
    check_word(32'(n), 32'h0000_0002);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0, rd);
    check_word(rd, exp);
  endtask

  task automatic cfg(input logic ge, input logic oe,
                     input logic [4:0] ga, input logic [9:0] oa,
                     input logic [4:0] gb, input logic [9:0] ob,
                     input logic [4:0] gc, input logic [9:0] oc);
    gen = ge;
    oen = oe;
    {g11o, o11o, g11e, o11e, g12, o12} = {ga, oa, gb, ob, gc, oc};
    wr(8'h0C, {19'h0, ge, 3'h0, oe, 8'h00});
    wr(8'hA4, {16'h0, ga, 1'b0, oa});
    wr(8'hA8, {16'h0, gb, 1'b0, ob});
    wr(8'hAC, {16'h0, gc, 1'b0, oc});
  endtask

  // Offset first, then gain of N*0.2 dB, rounded half up, clipped
  function automatic logic [13:0] exp_out(input logic [13:0] s,
                                          input logic [9:0] o,
                                          input logic [4:0] g);
    int d;
    int f;
    int p;
    d = $signed(s);
    if (oen) d = d - $signed(o);
    f = 16384;
    if (gen) f = $rtoi(16384.0 * (10.0 ** (g * 0.01)) + 0.5);
    p = (d * f + 8192) >>> 14;
    if (p > 8191) p = 8191;
    if (p < -8192) p = -8192;
    return p[13:0];
  endfunction

  // Odd then even conv11 sample back to back, conv12 alongside
  task automatic smp2(input logic [13:0] a0, input logic [13:0] a1,
                      input logic [13:0] c0, input logic [13:0] c1);
    @(posedge clk_i);
    {conv11_valid_i, conv11_odd_i, conv12_valid_i} <= 3'h7;
    conv11_sample_i <= a0;
    conv12_sample_i <= c0;
    @(posedge clk_i);
    conv11_odd_i <= 1'b0;
    conv11_sample_i <= a1;
    conv12_sample_i <= c1;
    @(posedge clk_i);
    {conv11_valid_i, conv12_valid_i} <= 2'h0;
    #1;
    check_smp({conv11_valid_o, conv11_odd_o, conv11_sample_o},
              {2'h3, exp_out(a0, o11o, g11o)});
    check_smp({conv12_valid_o, 1'b1, conv12_sample_o},
              {2'h3, exp_out(c0, o12, g12)});
    @(posedge clk_i);
    #1;
    check_smp({conv11_valid_o, conv11_odd_o, conv11_sample_o},
              {2'h2, exp_out(a1, o11e, g11e)});
    check_smp({conv12_valid_o, 1'b1, conv12_sample_o},
              {2'h3, exp_out(c1, o12, g12)});
  endtask

  // Main sequence
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {conv11_valid_i, conv11_odd_i, conv12_valid_i} = 3'h0;
    {conv11_sample_i, conv12_sample_i} = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (codes[i]) begin
      rdchk(8'hA4 + 8'(4 * (i % 3)), 32'h0);
    end
    rdchk(8'h0C, 32'h0);
    wr(8'hA8, 32'h0000_FBFF);
    rdchk(8'hA8, 32'h0000_FBFF);
    rdchk(8'hF0, 32'h0);
    cfg(0, 0, 5'h1F, 10'h1F3, 5'h0A, 10'h3F0, 5'h10, 10'h200);
    smp2(14'h0100, 14'h3F00, 14'h1FFF, 14'h2000);
    cfg(0, 1, 5'h1F, 10'h1F3, 5'h0A, 10'h3F0, 5'h10, 10'h200);
    smp2(14'h0100, 14'h3F00, 14'h0005, 14'h3FFB);
    foreach (codes[i]) begin
      cfg(1, 0, codes[i], 10'h0, 5'h1F - codes[i], 10'h0, codes[i], 10'h0);
      smp2(14'h0C35, 14'h3456, 14'h3001, 14'h0777);
    end
    cfg(1, 1, 5'h1F, 10'h200, 5'h1F, 10'h1FF, 5'h03, 10'h1FF);
    smp2(14'h1FFF, 14'h2000, 14'h1800, 14'h2500);
    rdchk(8'h0C, 32'h0000_1100);
    rdchk(8'hC0, {2'h0, exp_out(14'h2500, 10'h1FF, 5'h03), 2'h0,
                  exp_out(14'h2000, 10'h1FF, 5'h1F)});
    rdchk(8'hC4, 32'h0000_000E);
    wr(8'hC4, 32'h0000_0000);
    rdchk(8'hC4, 32'h0000_0000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'hA4, 32'h0);
    rdchk(8'hAC, 32'h0);
    rdchk(8'h0C, 32'h0);
    give_verdict();
  end

  // Watchdog well beyond the fewer than 200 cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
`default_nettype wire
